// [wdtew_pkg.sv]
// constants, field layout and decode helpers of the watchdog register block
package wdtew_pkg;

   // ----------------------------------------------------------------
   // bus geometry and register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam int ADR_W = 6;
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_CONFIG = 4'h1;
   localparam logic [3:0] IDX_EW_CTRL = 4'h2;
   localparam logic [3:0] IDX_EN_CLR = 4'h4;
   localparam logic [3:0] IDX_EN_SET = 4'h5;
   localparam logic [3:0] IDX_FLAGS = 4'h6;
   localparam logic [3:0] IDX_STATUS = 4'h7;
   localparam logic [3:0] IDX_KEY = 4'h8;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_LOCK_BIT = 7;
   localparam int CTRL_WIN_BIT = 2;
   localparam int CTRL_EN_BIT = 1;
   localparam int CFG_WIN_LSB = 4;
   localparam int CFG_PER_LSB = 0;
   localparam int EW_OFF_LSB = 0;
   localparam int EW_BIT = 0;
   localparam int STATUS_BUSY_BIT = 7;

   // ----------------------------------------------------------------
   // reset values, key and timing
   // ----------------------------------------------------------------
   localparam logic RST_IRQ_EN = 1'b0;
   localparam logic RST_FLAG = 1'b0;
   localparam logic RST_BUSY = 1'b0;
   localparam logic [7:0] SERVICE_KEY = 8'hA5;
   localparam logic [3:0] CODE_MAX = 4'hB;
   localparam logic [15:0] BASE_CYCLES = 16'h0008;
   localparam logic [1:0] SYNC_TICKS = 2'h2;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic {SYNC_IDLE, SYNC_WAIT} wdtew_sync_t;

   // period code to watchdog clock count, zero for reserved codes
   function automatic logic [15:0] wdtew_cycles(input logic [3:0] code);
      if (code > CODE_MAX) begin
         return 16'h0000;
      end
      return 16'(BASE_CYCLES << code);
   endfunction : wdtew_cycles

endpackage : wdtew_pkg

// [wdtew_counter.sv]
// watchdog period counter stepped by watchdog clock ticks
`timescale 1ns/100ps
module wdtew_counter
   import wdtew_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic enable_i,
   input wire logic window_en_i,
   input wire logic [3:0] period_i,
   input wire logic [3:0] window_i,
   input wire logic [3:0] ew_offset_i,
   input wire logic restart_i,
   output logic early_warn_o,
   output logic expire_o,
   output logic violation_o
);

   // ----------------------------------------------------------------
   // counting
   // ----------------------------------------------------------------
   logic [15:0] cnt_reg, cnt_next;
   logic ew_done_reg, ew_done_next;
   logic ew_reg, ew_next;
   logic exp_reg, exp_next;
   logic viol_reg, viol_next;
   logic [15:0] closed_cyc;
   logic [15:0] total_cyc;
   logic [15:0] ew_cyc;
   logic [15:0] cnt_inc;

   always_comb begin
      closed_cyc = window_en_i ? wdtew_cycles(window_i) : 16'h0000;
      total_cyc = 16'(closed_cyc + wdtew_cycles(period_i));
      ew_cyc = wdtew_cycles(ew_offset_i);
      cnt_inc = 16'(cnt_reg + 16'h0001);
      cnt_next = cnt_reg;
      ew_done_next = ew_done_reg;
      ew_next = 1'b0;
      exp_next = 1'b0;
      viol_next = 1'b0;
      if (!enable_i) begin
         cnt_next = 16'h0000;
         ew_done_next = 1'b0;
      end else if (restart_i) begin
         viol_next = window_en_i && (cnt_reg < closed_cyc);
         cnt_next = 16'h0000;
         ew_done_next = 1'b0;
      end else if (tick_i) begin
         if (total_cyc != 16'h0000 && cnt_inc == total_cyc) begin
            exp_next = 1'b1;
            cnt_next = 16'h0000;
            ew_done_next = 1'b0;
         end else begin
            cnt_next = cnt_inc;
         end
         if (!ew_done_reg && ew_cyc != 16'h0000 && cnt_inc == ew_cyc) begin
            ew_next = 1'b1;
            ew_done_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 16'h0000;
         ew_done_reg <= 1'b0;
         ew_reg <= 1'b0;
         exp_reg <= 1'b0;
         viol_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         ew_done_reg <= ew_done_next;
         ew_reg <= ew_next;
         exp_reg <= exp_next;
         viol_reg <= viol_next;
      end
   end

   assign early_warn_o = ew_reg;
   assign expire_o = exp_reg;
   assign violation_o = viol_reg;

endmodule : wdtew_counter

// [wdtew_top.sv]
// watchdog register block with early warning, key service and sync status
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
module wdtew_top
   import wdtew_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic watchdog_clock_i,
   input wire logic [7:0] nvm_ctrl_i,
   input wire logic [7:0] nvm_config_i,
   input wire logic [3:0] nvm_ew_offset_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   output logic sys_reset_o
);

   // ----------------------------------------------------------------
   // watchdog clock sampling
   // ----------------------------------------------------------------
   logic wclk_s1_reg;
   logic wclk_s2_reg;
   logic wclk_s3_reg;
   logic tick;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wclk_s1_reg <= 1'b0;
         wclk_s2_reg <= 1'b0;
         wclk_s3_reg <= 1'b0;
      end else begin
         wclk_s1_reg <= watchdog_clock_i;
         wclk_s2_reg <= wclk_s1_reg;
         wclk_s3_reg <= wclk_s2_reg;
      end
   end

   assign tick = wclk_s2_reg & ~wclk_s3_reg;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   logic req;
   logic [3:0] idx;
   logic [7:0] wbyte;
   logic key_ok;
   logic sync_need;
   logic stall;
   logic go;
   logic wr_go;
   logic busy_reg, busy_next;

   assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign idx = wb_adr_i[ADR_W-1:2];
   assign wbyte = wb_dat_i[7:0];
   assign key_ok = (wbyte == SERVICE_KEY);
   assign sync_need = wb_we_i & wb_sel_i[0] &
      ((idx == IDX_CTRL) | (idx == IDX_CONFIG) |
       ((idx == IDX_KEY) & key_ok));
   assign stall = sync_need & busy_reg;
   assign go = req & ~stall;
   assign wr_go = go & wb_we_i & wb_sel_i[0];

   // ----------------------------------------------------------------
   // software-visible registers
   // ----------------------------------------------------------------
   logic lock_reg, lock_next;
   logic win_en_reg, win_en_next;
   logic en_reg, en_next;
   logic [3:0] cfg_win_reg, cfg_win_next;
   logic [3:0] cfg_per_reg, cfg_per_next;
   logic [3:0] ew_off_reg, ew_off_next;
   logic irq_en_reg, irq_en_next;
   logic flag_reg, flag_next;
   logic rst_req_reg, rst_req_next;
   logic irq_reg, irq_next;
   logic ew_evt;
   logic expire_evt;
   logic viol_evt;

   always_comb begin
      lock_next = lock_reg;
      win_en_next = win_en_reg;
      en_next = en_reg;
      cfg_win_next = cfg_win_reg;
      cfg_per_next = cfg_per_reg;
      ew_off_next = ew_off_reg;
      irq_en_next = irq_en_reg;
      flag_next = flag_reg;
      rst_req_next = rst_req_reg;
      if (wr_go) begin
         case (idx)
            IDX_CTRL: begin
               if (!lock_reg) begin
                  lock_next = wbyte[CTRL_LOCK_BIT];
                  en_next = wbyte[CTRL_EN_BIT] | wbyte[CTRL_LOCK_BIT];
                  if (!en_reg) begin
                     win_en_next = wbyte[CTRL_WIN_BIT];
                  end
               end
            end
            IDX_CONFIG: begin
               if (!lock_reg && !en_reg) begin
                  cfg_win_next = wbyte[CFG_WIN_LSB +: 4];
                  cfg_per_next = wbyte[CFG_PER_LSB +: 4];
               end
            end
            IDX_EW_CTRL: begin
               if (!lock_reg && !en_reg) begin
                  ew_off_next = wbyte[EW_OFF_LSB +: 4];
               end
            end
            IDX_EN_CLR: begin
               if (wbyte[EW_BIT]) begin
                  irq_en_next = 1'b0;
               end
            end
            IDX_EN_SET: begin
               if (wbyte[EW_BIT]) begin
                  irq_en_next = 1'b1;
               end
            end
            IDX_FLAGS: begin
               if (wbyte[EW_BIT]) begin
                  flag_next = 1'b0;
               end
            end
            IDX_KEY: begin
               if (!key_ok) begin
                  rst_req_next = 1'b1;
               end
            end
            default: begin
               flag_next = flag_reg;
            end
         endcase
      end
      // event sets flag, wins over clear
      if (ew_evt) begin
         flag_next = 1'b1;
      end
      if (expire_evt || viol_evt) begin
         rst_req_next = 1'b1;
      end
      irq_next = flag_next & irq_en_next;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_reg <= nvm_ctrl_i[CTRL_LOCK_BIT];
         win_en_reg <= nvm_ctrl_i[CTRL_WIN_BIT];
         en_reg <= nvm_ctrl_i[CTRL_EN_BIT] | nvm_ctrl_i[CTRL_LOCK_BIT];
         cfg_win_reg <= nvm_config_i[CFG_WIN_LSB +: 4];
         cfg_per_reg <= nvm_config_i[CFG_PER_LSB +: 4];
         ew_off_reg <= nvm_ew_offset_i;
         irq_en_reg <= RST_IRQ_EN;
         flag_reg <= RST_FLAG;
         rst_req_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         lock_reg <= lock_next;
         win_en_reg <= win_en_next;
         en_reg <= en_next;
         cfg_win_reg <= cfg_win_next;
         cfg_per_reg <= cfg_per_next;
         ew_off_reg <= ew_off_next;
         irq_en_reg <= irq_en_next;
         flag_reg <= flag_next;
         rst_req_reg <= rst_req_next;
         irq_reg <= irq_next;
      end
   end

   // ----------------------------------------------------------------
   // transfer to watchdog clock side
   // ----------------------------------------------------------------
   wdtew_sync_t sync_reg, sync_next;
   logic [1:0] scnt_reg, scnt_next;
   logic key_pend_reg, key_pend_next;
   logic act_en_reg, act_en_next;
   logic act_win_en_reg, act_win_en_next;
   logic [3:0] act_win_reg, act_win_next;
   logic [3:0] act_per_reg, act_per_next;
   logic restart_reg, restart_next;

   always_comb begin
      sync_next = sync_reg;
      scnt_next = scnt_reg;
      busy_next = busy_reg;
      key_pend_next = key_pend_reg;
      act_en_next = act_en_reg;
      act_win_en_next = act_win_en_reg;
      act_win_next = act_win_reg;
      act_per_next = act_per_reg;
      restart_next = 1'b0;
      case (sync_reg)
         SYNC_IDLE: begin
            if (go && sync_need) begin
               busy_next = 1'b1;
               scnt_next = 2'h0;
               key_pend_next = (idx == IDX_KEY);
               sync_next = SYNC_WAIT;
            end
         end
         SYNC_WAIT: begin
            if (tick) begin
               scnt_next = 2'(scnt_reg + 2'h1);
               if (scnt_next == SYNC_TICKS) begin
                  act_en_next = en_reg;
                  act_win_en_next = win_en_reg;
                  act_win_next = cfg_win_reg;
                  act_per_next = cfg_per_reg;
                  restart_next = key_pend_reg;
                  key_pend_next = 1'b0;
                  busy_next = 1'b0;
                  sync_next = SYNC_IDLE;
               end
            end
         end
         default: begin
            sync_next = SYNC_IDLE;
            busy_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_reg <= SYNC_IDLE;
         scnt_reg <= 2'h0;
         busy_reg <= RST_BUSY;
         key_pend_reg <= 1'b0;
         act_en_reg <= nvm_ctrl_i[CTRL_EN_BIT] | nvm_ctrl_i[CTRL_LOCK_BIT];
         act_win_en_reg <= nvm_ctrl_i[CTRL_WIN_BIT];
         act_win_reg <= nvm_config_i[CFG_WIN_LSB +: 4];
         act_per_reg <= nvm_config_i[CFG_PER_LSB +: 4];
         restart_reg <= 1'b0;
      end else begin
         sync_reg <= sync_next;
         scnt_reg <= scnt_next;
         busy_reg <= busy_next;
         key_pend_reg <= key_pend_next;
         act_en_reg <= act_en_next;
         act_win_en_reg <= act_win_en_next;
         act_win_reg <= act_win_next;
         act_per_reg <= act_per_next;
         restart_reg <= restart_next;
      end
   end

   // ----------------------------------------------------------------
   // period counter
   // ----------------------------------------------------------------
   wdtew_counter u_counter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .enable_i(act_en_reg),
      .window_en_i(act_win_en_reg),
      .period_i(act_per_reg),
      .window_i(act_win_reg),
      .ew_offset_i(ew_off_reg),
      .restart_i(restart_reg),
      .early_warn_o(ew_evt),
      .expire_o(expire_evt),
      .violation_o(viol_evt)
   );

   // ----------------------------------------------------------------
   // read data and acknowledge
   // ----------------------------------------------------------------
   always_comb begin
      ack_next = go;
      dat_next = 32'h0000_0000;
      if (go && !wb_we_i) begin
         case (idx)
            IDX_CTRL: begin
               dat_next[CTRL_LOCK_BIT] = lock_reg;
               dat_next[CTRL_WIN_BIT] = win_en_reg;
               dat_next[CTRL_EN_BIT] = en_reg;
            end
            IDX_CONFIG: begin
               dat_next[CFG_WIN_LSB +: 4] = cfg_win_reg;
               dat_next[CFG_PER_LSB +: 4] = cfg_per_reg;
            end
            IDX_EW_CTRL: begin
               dat_next[EW_OFF_LSB +: 4] = ew_off_reg;
            end
            IDX_EN_CLR, IDX_EN_SET: begin
               dat_next[EW_BIT] = irq_en_reg;
            end
            IDX_FLAGS: begin
               dat_next[EW_BIT] = flag_reg;
            end
            IDX_STATUS: begin
               dat_next[STATUS_BUSY_BIT] = busy_reg;
            end
            default: begin
               dat_next = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign irq_o = irq_reg;
   assign sys_reset_o = rst_req_reg;

endmodule : wdtew_top

// [wdtew_top_props.sv]
// port-level checks of the watchdog register block
`timescale 1ns/100ps
module wdtew_top_props
   import wdtew_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic watchdog_clock_i,
   input wire logic [7:0] nvm_ctrl_i,
   input wire logic [7:0] nvm_config_i,
   input wire logic [3:0] nvm_ew_offset_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq_o,
   input wire logic sys_reset_o
);
   // ------------------------------------------------------------
   // bus answer, interrupt and system reset
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_read_no_stall: assert property (
      wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o |=> wb_ack_o)
      else $error("read not answered next cycle");
   a_stall_bounded: assert property (
      $rose(wb_stb_i) |-> ##[1:100] wb_ack_o)
      else $error("access never answered");
   a_data_gated: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_enclr_drops_irq: assert property (
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[0]
      && wb_adr_i[5:2] == IDX_EN_CLR |=> !irq_o)
      else $error("irq stayed after enable clear");
   a_w1c_drops_irq: assert property (
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[0]
      && wb_adr_i[5:2] == IDX_FLAGS |=> !irq_o)
      else $error("irq stayed after flag clear");
   a_bad_key_reset: assert property (
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[5:2] == IDX_KEY
      && wb_dat_i[7:0] != SERVICE_KEY |-> ##[0:1] sys_reset_o)
      else $error("wrong key gave no system reset");
   a_reset_sticky: assert property (sys_reset_o |=> sys_reset_o)
      else $error("system reset dropped");
   a_reset_quiet: assert property (
      disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && !sys_reset_o)
      else $error("outputs active after reset");
endmodule : wdtew_top_props

bind wdtew_top wdtew_top_props chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .watchdog_clock_i(watchdog_clock_i), .nvm_ctrl_i(nvm_ctrl_i),
   .nvm_config_i(nvm_config_i), .nvm_ew_offset_i(nvm_ew_offset_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
   .sys_reset_o(sys_reset_o));

// [wdtew_top_tb.sv]
// self-checking bench of the watchdog register block
`timescale 1ns/100ps
`define CHK(a, e) \
   begin \
      checks++; \
      if ((a) !== (e)) begin \
         errors++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); \
      end \
   end
module wdtew_top_tb
   import wdtew_pkg::*;
();
   // ------------------------------------------------------------
   // stimulus signals and clocks
   // ------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [ADR_W-1:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic watchdog_clock_i = 1'b0;
   logic [7:0] nvm_ctrl_i = 8'h00;
   logic [7:0] nvm_config_i = 8'h02;
   logic [3:0] nvm_ew_offset_i = 4'h6;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, irq_o, sys_reset_o;
   logic [31:0] rd_q;
   int errors = 0, checks = 0, ticks = 0;

   always #2 clk_i = ~clk_i;
   always #13 watchdog_clock_i = ~watchdog_clock_i;
   always @(posedge watchdog_clock_i) ticks++;

   wdtew_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .watchdog_clock_i(watchdog_clock_i), .nvm_ctrl_i(nvm_ctrl_i),
      .nvm_config_i(nvm_config_i), .nvm_ew_offset_i(nvm_ew_offset_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
      .sys_reset_o(sys_reset_o));

   // ------------------------------------------------------------
   // bus cycle and helper tasks
   // ------------------------------------------------------------
   task automatic acc(input logic we, input logic [3:0] idx,
         input logic [7:0] d);
      int n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'h0};
      wb_sel_i <= 4'hF;
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 300);
      if (n >= 300) errors++;
      rd_q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask : acc

   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      acc(1'b1, i, d);
   endtask : wr

   task automatic rdchk(input logic [3:0] i, input logic [7:0] e);
      acc(1'b0, i, 8'h00);
      `CHK(rd_q, e)
   endtask : rdchk

   // polls irq_o, or sys_reset_o when sel_rst is set
   task automatic wait_hi(input logic sel_rst, input int lim);
      int n = 0;
      while ((sel_rst ? sys_reset_o : irq_o) !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= lim) errors++;
   endtask : wait_hi

   // waits for the sync busy bit to drop, then notes the tick count
   task automatic wait_idle(output int t0);
      int n = 0;
      do begin
         acc(1'b0, IDX_STATUS, 8'h00);
         n++;
      end while (rd_q !== 8'h00 && n < 60);
      `CHK(rd_q, 8'h00)
      t0 = ticks;
   endtask : wait_idle

   task automatic do_reset(input logic [7:0] ctrl);
      rst_i <= 1'b1;
      nvm_ctrl_i <= ctrl;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask : do_reset

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_values;
      rdchk(IDX_FLAGS, 8'h00);
      rdchk(IDX_EN_SET, 8'h00);
      rdchk(IDX_STATUS, 8'h00);
      rdchk(IDX_EW_CTRL, 8'h06);
      rdchk(IDX_KEY, 8'h00);
      rdchk(4'h3, 8'h00);
   endtask : t_reset_values

   task automatic t_enables;
      wr(IDX_EN_SET, 8'h00);
      rdchk(IDX_EN_SET, 8'h00);
      wr(IDX_EN_SET, 8'h01);
      rdchk(IDX_EN_CLR, 8'h01);
      wr(IDX_EN_CLR, 8'h00);
      rdchk(IDX_EN_SET, 8'h01);
      wr(IDX_EN_CLR, 8'h01);
      rdchk(IDX_EN_SET, 8'h00);
      wr(IDX_EW_CTRL, 8'h0B);
      rdchk(IDX_EW_CTRL, 8'h0B);
      wr(IDX_EW_CTRL, 8'h00);
   endtask : t_enables

   task automatic t_run;
      int t0;
      wr(IDX_CTRL, 8'h02);
      rdchk(IDX_STATUS, 8'h80);
      wr(IDX_KEY, SERVICE_KEY);
      `CHK(sys_reset_o, 1'b0)
      wait_idle(t0);
      wr(IDX_EW_CTRL, 8'h05);
      rdchk(IDX_EW_CTRL, 8'h00);
      wr(IDX_EN_SET, 8'h01);
      wait_hi(1'b0, 200);
      `CHK((ticks - t0) inside {[7:10]}, 1'b1)
      rdchk(IDX_FLAGS, 8'h01);
      wr(IDX_FLAGS, 8'h00);
      `CHK(irq_o, 1'b1)
      wr(IDX_FLAGS, 8'h01);
      rdchk(IDX_FLAGS, 8'h00);
      wr(IDX_KEY, SERVICE_KEY);
      wait_idle(t0);
      wait_hi(1'b1, 400);
      `CHK((ticks - t0) inside {[30:35]}, 1'b1)
   endtask : t_run

   task automatic t_bad_key;
      do_reset(8'h00);
      wr(IDX_KEY, 8'h5A);
      `CHK(sys_reset_o, 1'b1)
   endtask : t_bad_key

   task automatic t_lock;
      do_reset(8'h82);
      wr(IDX_CTRL, 8'h00);
      rdchk(IDX_CTRL, 8'h82);
      wr(IDX_CONFIG, 8'h05);
      rdchk(IDX_CONFIG, 8'h02);
      wr(IDX_EW_CTRL, 8'h03);
      rdchk(IDX_EW_CTRL, 8'h06);
   endtask : t_lock

   // window mode: late service passes, early service resets
   task automatic t_window;
      int t0;
      do_reset(8'h00);
      wr(IDX_CTRL, 8'h06);
      rdchk(IDX_CTRL, 8'h06);
      wait_idle(t0);
      repeat (80) @(posedge clk_i);
      wr(IDX_KEY, SERVICE_KEY);
      wait_idle(t0);
      `CHK(sys_reset_o, 1'b0)
      wr(IDX_KEY, SERVICE_KEY);
      wait_idle(t0);
      wait_hi(1'b1, 20);
      `CHK(sys_reset_o, 1'b1)
   endtask : t_window

   task automatic final_report;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   initial begin
      do_reset(8'h00);
      t_reset_values();
      t_enables();
      t_run();
      t_bad_key();
      t_lock();
      t_window();
      final_report();
   end

   // whole run needs a few hundred cycles; this is ten thousand
   initial begin
      #40000;
      errors++;
      final_report();
   end
endmodule : wdtew_top_tb
